// >>> src/mccr_map.vh
// constants of the main clock / time-base controller: offsets, fields, counts
// assumes inclusion by bare name from the design files of this block
`ifndef MCCR_MAP_VH
`define MCCR_MAP_VH

// register word indices on the avalon slave
`define MCCR_IDX_CTRL      2'h0
`define MCCR_IDX_EVT_STAT  2'h1
`define MCCR_IDX_EVT_MASK  2'h2

// control/status fields
`define MCCR_BIT_CLKOUT    7
`define MCCR_BIT_DIV_HI    6
`define MCCR_BIT_DIV_LO    5
`define MCCR_BIT_SLOW      4
`define MCCR_BIT_TB_HI     3
`define MCCR_BIT_TB_LO     2
`define MCCR_BIT_TIE       1
`define MCCR_BIT_FLAG      0
`define MCCR_CTRL_RESET    8'h00

// event status / mask bits
`define MCCR_EVT_W         3
`define MCCR_EVT_TICK      0
`define MCCR_EVT_AHALT_END 1
`define MCCR_EVT_HALT_END  2
`define MCCR_EVT_RESET     3'h0

// slow-mode divider terminal counts (divide by 2, 4, 8, 16)
`define MCCR_DIV_LAST0     4'h1
`define MCCR_DIV_LAST1     4'h3
`define MCCR_DIV_LAST2     4'h7
`define MCCR_DIV_LAST3     4'hf
`define MCCR_DIV_NORMAL    4'h0

// time-base periods in oscillator cycles
`define MCCR_TB_PERIOD0    18'd16000
`define MCCR_TB_PERIOD1    18'd32000
`define MCCR_TB_PERIOD2    18'd80000
`define MCCR_TB_PERIOD3    18'd200000

// power mode states
`define MCCR_ST_RUN        2'h0
`define MCCR_ST_AHALT      2'h1
`define MCCR_ST_HALT       2'h2

`endif

// >>> src/mccr_prescaler.v
// cpu clock prescaler: one-cycle cpu clock enable and a clock-out phase level
// assumes clk is the oscillator clock; run low freezes the divider
`timescale 1ns/1ns
`default_nettype none
`include "mccr_map.vh"

module mccr_prescaler (
  input  wire       clk,
  input  wire       resetn,
  input  wire       run,
  input  wire       slow_select,
  input  wire [1:0] slow_divider_select,
  output reg        cpu_en_q,
  output reg        phase_q
);

  reg  [3:0] cnt_q;
  reg  [3:0] last;
  wire [3:0] cnt_n;

  always @* begin
    case (slow_divider_select)
      2'h0:    last = `MCCR_DIV_LAST0;
      2'h1:    last = `MCCR_DIV_LAST1;
      2'h2:    last = `MCCR_DIV_LAST2;
      default: last = `MCCR_DIV_LAST3;
    endcase
    if (!slow_select) begin
      last = `MCCR_DIV_NORMAL;
    end
  end

  assign cnt_n = (cnt_q >= last) ? 4'h0 : cnt_q + 4'h1;

  // divider change lands cleanly: a shorter count wraps at once via >=
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q    <= 4'h0;
      cpu_en_q <= 1'b0;
      phase_q  <= 1'b0;
    end else if (run) begin
      cnt_q    <= cnt_n;
      cpu_en_q <= (cnt_n == 4'h0);
      if (last == `MCCR_DIV_NORMAL) begin
        phase_q <= ~phase_q;
      end else begin
        phase_q <= (cnt_n <= {1'b0, last[3:1]});
      end
    end else begin
      cpu_en_q <= 1'b0;
    end
  end

endmodule // mccr_prescaler

`default_nettype wire

// >>> src/mccr_timebase.v
// periodic time-base down counter with a one-cycle tick at each period end
// assumes clk is the oscillator clock; run low freezes the count
`timescale 1ns/1ns
`default_nettype none
`include "mccr_map.vh"

module mccr_timebase #(
  parameter [17:0] PERIOD0 = `MCCR_TB_PERIOD0,
  parameter [17:0] PERIOD1 = `MCCR_TB_PERIOD1,
  parameter [17:0] PERIOD2 = `MCCR_TB_PERIOD2,
  parameter [17:0] PERIOD3 = `MCCR_TB_PERIOD3
) (
  input  wire       clk,
  input  wire       resetn,
  input  wire       run,
  input  wire [1:0] time_base_select,
  output reg        tick_q
);

  reg  [17:0] cnt_q;
  reg  [17:0] period;

  always @* begin
    case (time_base_select)
      2'h0:    period = PERIOD0;
      2'h1:    period = PERIOD1;
      2'h2:    period = PERIOD2;
      default: period = PERIOD3;
    endcase
  end

  // selection is sampled only at reload, so a running period never shifts
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q  <= PERIOD0 - 18'd1;
      tick_q <= 1'b0;
    end else if (run) begin
      if (cnt_q == 18'd0) begin
        cnt_q  <= period - 18'd1;
        tick_q <= 1'b1;
      end else begin
        cnt_q  <= cnt_q - 18'd1;
        tick_q <= 1'b0;
      end
    end else begin
      tick_q <= 1'b0;
    end
  end

endmodule // mccr_timebase

`default_nettype wire

// >>> src/mccr_top.v
// main clock controller: cpu clock prescaler, clock-out, time-base tick
// assumes clk is the oscillator clock and all cpu inputs share that clock
//
// What this block does
// - wait mode leaves everything running; tick wakes
// - active halt: counter runs, registers frozen
// - full halt freezes counter and registers
// - tick request needs enable and unmasked cpu
// - tick wakes active halt, never full halt
// - bit 7 routes cpu clock to pin
// - clock-out suspended during active halt
// - bits 6:5 pick slow divisor 2..16
// - bit 4 selects slow divided cpu clock
// - new time base applies from next period
// - bits 3:2 pick period 16000..200000 cycles
// - halt with tick enable enters active halt
// - bit 0 tick flag, cleared by reading
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "mccr_map.vh"

module mccr_top #(
  parameter [17:0] TB_PERIOD0 = `MCCR_TB_PERIOD0,
  parameter [17:0] TB_PERIOD1 = `MCCR_TB_PERIOD1,
  parameter [17:0] TB_PERIOD2 = `MCCR_TB_PERIOD2,
  parameter [17:0] TB_PERIOD3 = `MCCR_TB_PERIOD3
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire [1:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output wire        irq,
  input  wire        halt_instr,
  input  wire        wait_mode,
  input  wire        cpu_irq_mask,
  input  wire        halt_wake_irq,
  output wire        cpu_clk_en,
  output wire        clock_out_pin_o,
  output wire        clock_out_pin_oe,
  output wire        tick_irq_req,
  output wire        active_halt,
  output wire        full_halt,
  output wire        cpu_wake
);

  // control/status fields
  reg                    clock_out_enable_q;
  reg  [1:0]             slow_divider_select_q;
  reg                    slow_select_q;
  reg  [1:0]             time_base_select_q;
  reg                    tick_irq_enable_q;
  reg                    tick_flag_q;
  reg                    tick_flag_d;

  // bus side
  reg                    ack_q;
  reg  [7:0]             readdata_q;
  reg  [7:0]             rd_mux;
  wire                   access;
  wire                   done_rd;
  wire                   done_wr;
  wire                   wr_ctrl;
  wire                   wr_mask;

  // event interrupt registers
  reg  [`MCCR_EVT_W-1:0] evt_stat_q;
  reg  [`MCCR_EVT_W-1:0] evt_stat_d;
  reg  [`MCCR_EVT_W-1:0] evt_mask_q;
  reg  [`MCCR_EVT_W-1:0] evt_set;
  reg  [`MCCR_EVT_W-1:0] evt_clr;

  // power mode
  reg  [1:0]             mode_q;
  reg  [1:0]             mode_d;
  reg                    ahalt_end;
  reg                    halt_end;
  wire                   regs_live;
  wire                   counter_run;
  wire                   tick;
  wire                   cpu_en;
  wire                   phase;

  // one wait state: request seen, answer on the following edge
  assign access          = (avs_read | avs_write) & ~ack_q;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign done_rd         = avs_read & ack_q;
  assign done_wr         = avs_write & ack_q & avs_byteenable[0];
  assign avs_readdata    = {24'h000000, readdata_q};

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access;
    end
  end

  // frozen registers in both halt states; writes are still answered
  assign regs_live = (mode_q == `MCCR_ST_RUN);
  assign wr_ctrl   = done_wr & regs_live & (avs_address == `MCCR_IDX_CTRL);
  assign wr_mask   = done_wr & regs_live & (avs_address == `MCCR_IDX_EVT_MASK);

  always @* begin
    case (avs_address)
      `MCCR_IDX_CTRL: begin
        rd_mux = {clock_out_enable_q,
                  slow_divider_select_q,
                  slow_select_q,
                  time_base_select_q,
                  tick_irq_enable_q,
                  tick_flag_q};
      end
      `MCCR_IDX_EVT_STAT: begin
        rd_mux = {5'h00, evt_stat_q};
      end
      `MCCR_IDX_EVT_MASK: begin
        rd_mux = {5'h00, evt_mask_q};
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // data is captured one edge before completion and held while it stands
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      readdata_q <= 8'h00;
    end else if (access & avs_read) begin
      readdata_q <= rd_mux;
    end
  end

  // control fields, software read/write
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clock_out_enable_q    <= 1'b0;
      slow_divider_select_q <= 2'h0;
      slow_select_q         <= 1'b0;
      time_base_select_q    <= 2'h0;
      tick_irq_enable_q     <= 1'b0;
    end else if (wr_ctrl) begin
      clock_out_enable_q    <= avs_writedata[`MCCR_BIT_CLKOUT];
      slow_divider_select_q <= avs_writedata[`MCCR_BIT_DIV_HI:`MCCR_BIT_DIV_LO];
      slow_select_q         <= avs_writedata[`MCCR_BIT_SLOW];
      time_base_select_q    <= avs_writedata[`MCCR_BIT_TB_HI:`MCCR_BIT_TB_LO];
      tick_irq_enable_q     <= avs_writedata[`MCCR_BIT_TIE];
    end
  end

  // tick flag: only the value actually returned is cleared, so a tick
  // between capture and completion survives; a set always wins
  always @* begin
    tick_flag_d = tick_flag_q;
    if (done_rd & regs_live & (avs_address == `MCCR_IDX_CTRL) &
        readdata_q[`MCCR_BIT_FLAG]) begin
      tick_flag_d = 1'b0;
    end
    if (tick) begin
      tick_flag_d = 1'b1;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_flag_q <= 1'b0;
    end else begin
      tick_flag_q <= tick_flag_d;
    end
  end

  // cpu-facing request; masked cpu keeps it pending in the flag
  assign tick_irq_req = tick_flag_q & tick_irq_enable_q & ~cpu_irq_mask;

  // power mode machine
  always @* begin
    mode_d    = mode_q;
    ahalt_end = 1'b0;
    halt_end  = 1'b0;
    case (mode_q)
      `MCCR_ST_RUN: begin
        if (halt_instr) begin
          if (tick_irq_enable_q) begin
            mode_d = `MCCR_ST_AHALT;
          end else begin
            mode_d = `MCCR_ST_HALT;
          end
        end
      end
      `MCCR_ST_AHALT: begin
        if (tick_irq_req | halt_wake_irq) begin
          mode_d    = `MCCR_ST_RUN;
          ahalt_end = 1'b1;
        end
      end
      `MCCR_ST_HALT: begin
        if (halt_wake_irq) begin
          mode_d   = `MCCR_ST_RUN;
          halt_end = 1'b1;
        end
      end
      default: begin
        mode_d = `MCCR_ST_RUN;
      end
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= `MCCR_ST_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  assign active_halt = (mode_q == `MCCR_ST_AHALT);
  assign full_halt   = (mode_q == `MCCR_ST_HALT);

  // wait mode is only a cpu state here: it only lets a tick request raise cpu_wake
  assign cpu_wake = (wait_mode & tick_irq_req) |
                    (active_halt & (tick_irq_req | halt_wake_irq)) |
                    (full_halt & halt_wake_irq);

  // counter keeps going in wait and active halt, stops in full halt
  assign counter_run = ~full_halt;

  // software event bank: sticky, cleared by read of the returned bits
  always @* begin
    evt_set = {`MCCR_EVT_W{1'b0}};
    evt_set[`MCCR_EVT_TICK]      = tick;
    evt_set[`MCCR_EVT_AHALT_END] = ahalt_end;
    evt_set[`MCCR_EVT_HALT_END]  = halt_end;
    evt_clr = {`MCCR_EVT_W{1'b0}};
    if (done_rd & (avs_address == `MCCR_IDX_EVT_STAT)) begin
      evt_clr = readdata_q[`MCCR_EVT_W-1:0];
    end
    evt_stat_d = (evt_stat_q & ~evt_clr) | evt_set;
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evt_stat_q <= `MCCR_EVT_RESET;
      evt_mask_q <= `MCCR_EVT_RESET;
    end else begin
      evt_stat_q <= evt_stat_d;
      if (wr_mask) begin
        evt_mask_q <= avs_writedata[`MCCR_EVT_W-1:0];
      end
    end
  end

  assign irq = |(evt_stat_q & evt_mask_q);

  // cpu clock stops in both halt states
  mccr_prescaler u_prescaler (
    .clk                 (clk),
    .resetn              (resetn),
    .run                 (regs_live),
    .slow_select         (slow_select_q),
    .slow_divider_select (slow_divider_select_q),
    .cpu_en_q            (cpu_en),
    .phase_q             (phase)
  );

  mccr_timebase #(
    .PERIOD0 (TB_PERIOD0),
    .PERIOD1 (TB_PERIOD1),
    .PERIOD2 (TB_PERIOD2),
    .PERIOD3 (TB_PERIOD3)
  ) u_timebase (
    .clk              (clk),
    .resetn           (resetn),
    .run              (counter_run),
    .time_base_select (time_base_select_q),
    .tick_q           (tick)
  );

  assign cpu_clk_en = cpu_en;

  // pin released to port logic when clock-out is off or in active halt
  assign clock_out_pin_o  = phase & clock_out_enable_q & ~active_halt;
  assign clock_out_pin_oe = clock_out_enable_q & ~active_halt;

endmodule // mccr_top

`default_nettype wire

// >>> bench/mccr_chk.sv
// checker: port-level timing relations of the clock controller top
// assumes a bind onto mccr_top from the bench top file
`timescale 1ns/1ns
`default_nettype none
module mccr_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic halt_instr,
  input wire logic wait_mode,
  input wire logic cpu_irq_mask,
  input wire logic halt_wake_irq,
  input wire logic cpu_clk_en,
  input wire logic clock_out_pin_o,
  input wire logic clock_out_pin_oe,
  input wire logic tick_irq_req,
  input wire logic active_halt,
  input wire logic full_halt,
  input wire logic cpu_wake
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_BUS_ONE_WAIT: assert property ($rose(avs_read | avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer late");
  AST_MASK_BLOCKS: assert property (cpu_irq_mask |-> !tick_irq_req)
    else $error("tick request while masked");
  AST_AHALT_NO_CLKOUT: assert property (active_halt |-> !clock_out_pin_oe && !clock_out_pin_o)
    else $error("clock-out active in active halt");
  AST_PIN_IDLE: assert property (!clock_out_pin_oe |-> !clock_out_pin_o)
    else $error("pin level while not driven");
  // registered enable may still fire on the entry cycle
  AST_HALT_NO_CPU: assert property ((active_halt || full_halt) [*2] |-> !cpu_clk_en)
    else $error("cpu clock runs in halt");
  AST_ENTER_HALT: assert property (halt_instr && !active_halt && !full_halt |=>
    active_halt ^ full_halt) else $error("halt not entered");
  AST_FULL_HOLD: assert property (full_halt && !halt_wake_irq |=> full_halt)
    else $error("full halt left without wake source");
  AST_FULL_NO_WAKE: assert property (full_halt && !halt_wake_irq |-> !cpu_wake)
    else $error("wake from full halt by tick");
  AST_AHALT_WAKE: assert property (active_halt && tick_irq_req |->
    cpu_wake ##[1:2] !active_halt) else $error("active halt not ended by tick");
  AST_WAIT_WAKE: assert property (wait_mode && tick_irq_req |-> cpu_wake)
    else $error("no wake from wait");
  cover property (active_halt ##1 !active_halt);
  cover property (full_halt && halt_wake_irq);
  cover property (wait_mode && cpu_wake);
endmodule // mccr_chk
`default_nettype wire

// >>> bench/test_main_clock_rtc_controller.sv
// bench: registers, prescaler, time base, interrupts and halt modes
// assumes short time-base periods (16/32/80/200) set on the instance
`timescale 1ns/1ns
`default_nettype none
module test_main_clock_rtc_controller;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [1:0]  avs_address = 2'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        halt_instr = 1'b0;
  logic        wait_mode = 1'b0;
  logic        cpu_irq_mask = 1'b0;
  logic        halt_wake_irq = 1'b0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, irq, cpu_clk_en, pin_o, pin_oe;
  wire         tick_irq_req, active_halt, full_halt, cpu_wake;
  int          mismatches = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          p, g, hc;
  logic [7:0]  rd;
  logic [7:0]  r_ctl [5] = '{8'h02, 8'h96, 8'hba, 8'h5e, 8'hf2};
  logic [7:0]  r_div [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
  logic [7:0]  r_tb [5] = '{8'h10, 8'h20, 8'h50, 8'hc8, 8'h10};

  mccr_top #(.TB_PERIOD0(18'h10), .TB_PERIOD1(18'h20), .TB_PERIOD2(18'h50),
    .TB_PERIOD3(18'hc8)) i_dut (
    .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .halt_instr(halt_instr),
    .wait_mode(wait_mode), .cpu_irq_mask(cpu_irq_mask), .halt_wake_irq(halt_wake_irq),
    .cpu_clk_en(cpu_clk_en), .clock_out_pin_o(pin_o), .clock_out_pin_oe(pin_oe),
    .tick_irq_req(tick_irq_req), .active_halt(active_halt), .full_halt(full_halt),
    .cpu_wake(cpu_wake));

  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task summarize;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon transfer; request held until waitrequest is seen low at an edge
  task bus(input logic wr, input logic [1:0] a, input logic [7:0] d,
           output logic [7:0] q);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) mismatches++;
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  function logic sig(input int s);
    case (s)
      0: sig = tick_irq_req;
      1: sig = irq;
      2: sig = !active_halt;
      default: sig = cpu_clk_en;
    endcase
  endfunction

  // edges until the chosen signal is seen high, bounded
  task await(input int s, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sig(s) !== 1'b1 && n < lim);
    if (n >= lim) mismatches++;
  endtask

  // spacing of two flag sets; first set may still use the old period
  task tgap(output int gap);
    int t0, n;
    bus(0, 2'h0, 8'h00, rd);
    await(0, 500, n);
    t0 = cyc;
    bus(0, 2'h0, 8'h00, rd);
    await(0, 500, n);
    gap = cyc - t0;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    bus(0, 2'h0, 8'h00, rd);
    chk(rd, 8'h00);
    bus(0, 2'h2, 8'h00, rd);
    chk(rd, 8'h00);
    for (int i = 0; i < 5; i++) begin
      bus(1, 2'h0, r_ctl[i], rd); // whole-byte write, never read-modify-write
      bus(0, 2'h0, 8'h00, rd);
      chk(rd & 8'hfe, r_ctl[i]);
      chk({7'h0, pin_oe}, {7'h0, r_ctl[i][7]});
      for (int k = 0; k < 3; k++) await(3, 40, p);
      chk(p[7:0], r_div[i]);
      // half duty at every divisor: 8 high levels in any 16 cycles when driven
      hc = 0;
      repeat (16) begin
        @(posedge clk);
        hc = hc + pin_o;
      end
      chk(hc[7:0], r_ctl[i][7] ? 8'h08 : 8'h00);
      tgap(g);
      chk(g[7:0], r_tb[i]);
    end
    bus(0, 2'h0, 8'h00, rd);
    await(0, 500, p);
    g = cyc;
    bus(1, 2'h0, 8'h8e, rd);
    bus(0, 2'h0, 8'h00, rd);
    await(0, 500, p);
    g = cyc - g;
    chk(g[7:0], 8'h10);
    avs_byteenable <= 4'he;
    bus(1, 2'h0, 8'h00, rd);
    avs_byteenable <= 4'hf;
    bus(1, 2'h3, 8'hff, rd);
    bus(0, 2'h3, 8'h00, rd);
    chk(rd, 8'h00);
    bus(0, 2'h0, 8'h00, rd);
    chk(rd & 8'hfe, 8'h8e);
    bus(1, 2'h2, 8'h01, rd);
    await(1, 300, p);
    bus(0, 2'h1, 8'h00, rd);
    chk(rd & 8'h01, 8'h01);
    @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    bus(1, 2'h2, 8'h00, rd);
    repeat (210) @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    bus(0, 2'h1, 8'h00, rd);
    chk(rd & 8'h01, 8'h01);
    bus(0, 2'h0, 8'h00, rd);
    halt_instr <= 1'b1;
    @(posedge clk);
    halt_instr <= 1'b0;
    @(posedge clk);
    chk({6'h0, active_halt, pin_oe}, 8'h02);
    bus(1, 2'h0, 8'h00, rd);
    await(2, 300, p);
    bus(0, 2'h0, 8'h00, rd);
    chk(rd & 8'hfe, 8'h8e);
    bus(1, 2'h0, 8'h80, rd);
    halt_instr <= 1'b1;
    @(posedge clk);
    halt_instr <= 1'b0;
    repeat (250) @(posedge clk);
    chk({6'h0, full_halt, cpu_clk_en}, 8'h02);
    halt_wake_irq <= 1'b1;
    @(posedge clk);
    halt_wake_irq <= 1'b0;
    @(posedge clk);
    chk({7'h0, full_halt}, 8'h00);
    bus(0, 2'h1, 8'h00, rd);
    chk(rd & 8'h06, 8'h06);
    bus(1, 2'h0, 8'h02, rd);
    wait_mode <= 1'b1;
    bus(0, 2'h0, 8'h00, rd);
    await(0, 300, p);
    chk({7'h0, cpu_wake}, 8'h01);
    cpu_irq_mask <= 1'b1;
    repeat (2) @(posedge clk);
    chk({7'h0, tick_irq_req}, 8'h00);
    cpu_irq_mask <= 1'b0;
    wait_mode <= 1'b0;
    summarize;
  end

  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    summarize;
  end
endmodule // test_main_clock_rtc_controller

bind mccr_top mccr_chk i_chk (.clk(clk), .resetn(resetn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .halt_instr(halt_instr),
  .wait_mode(wait_mode), .cpu_irq_mask(cpu_irq_mask), .halt_wake_irq(halt_wake_irq),
  .cpu_clk_en(cpu_clk_en), .clock_out_pin_o(clock_out_pin_o),
  .clock_out_pin_oe(clock_out_pin_oe), .tick_irq_req(tick_irq_req),
  .active_halt(active_halt), .full_halt(full_halt), .cpu_wake(cpu_wake));
`default_nettype wire
